// ---- hdl/dtc_async_timer.sv ----
`default_nettype none
// ==========================================================
// pin-driven termination for dll-off operation, no latency added
module dtc_async_timer
   import dtc_pkg::*;
#(
   parameter int ON_MIN = ASYNC_ON_MIN_CYC,
   parameter int ON_MAX = ASYNC_ON_MAX_CYC,
   parameter int OFF_MIN = ASYNC_OFF_MIN_CYC,
   parameter int OFF_MAX = ASYNC_OFF_MAX_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic nom_o,
   output logic moving_o
);

   dtc_async_t state_q, state_d;
   logic lvl_q, lvl_d;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] min_c, max_c;

   // count from the sample; a pin flip back cancels the move
   always_comb
   begin
      min_c = pin_i ? 8'(ON_MIN) : 8'(OFF_MIN);
      max_c = pin_i ? 8'(ON_MAX) : 8'(OFF_MAX);
      state_d = state_q;
      lvl_d = lvl_q;
      case (state_q)
         AS_IDLE: cnt_d = 8'd1;
         default: cnt_d = cnt_q + 8'd1;
      endcase
      if (pin_i == lvl_q)
      begin
         state_d = AS_IDLE;
         cnt_d = 8'd0;
      end
      else if (cnt_d >= max_c)
      begin
         lvl_d = pin_i;          // R6 R7
         state_d = AS_IDLE;
         cnt_d = 8'd0;
      end
      else
      begin
         state_d = (cnt_d >= min_c) ? AS_MOVE : AS_WAIT; // R6 R7
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= AS_IDLE;
         lvl_q <= 1'b0;
         cnt_q <= 8'd0;
      end
      else
      begin
         state_q <= state_d;
         lvl_q <= lvl_d;
         cnt_q <= cnt_d;
      end
   end

   assign nom_o = lvl_q;
   assign moving_o = (state_q == AS_MOVE);

   a_async_settle: assert property ( // R6 R7
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(lvl_q) |-> ($past(cnt_q) + 8'd1 == $past(max_c)))
      else $error("async termination settled at wrong time");

   a_async_move: assert property ( // R6 R7
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(moving_o) |-> (cnt_q >= $past(min_c)))
      else $error("async termination began moving too early");

endmodule
`default_nettype wire

// ---- hdl/dtc_sched.sv ----
`default_nettype none
// ==========================================================
// event schedule: value written at slot idx appears at out_o
// after idx further edges
module dtc_sched
   import dtc_pkg::*;
#(
   parameter int DEPTH = DTC_SCHED_DEPTH,
   localparam int IW = $clog2(DEPTH)
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ins_i,
   input wire logic val_i,
   input wire logic [IW-1:0] idx_i,
   output logic out_o
);

   logic [DEPTH-1:0] slot_q;
   logic [DEPTH-1:0] slot_d;

   // shift toward slot 0, then overwrite the chosen slot
   always_comb
   begin
      slot_d = {1'b0, slot_q[DEPTH-1:1]};
      if (ins_i)
      begin
         slot_d[idx_i] = val_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         slot_q <= '0;
      else
         slot_q <= slot_d;
   end

   assign out_o = slot_q[0];

endmodule
`default_nettype wire

// ---- hdl/dtc_top.sv ----
// What this block does
// R1 - write termination starts write latency minus two, or minus three with long preamble
// R2 - chop-4 release at on latency plus 4, 7, 5 or 8 by preamble and crc
// R3 - full burst release at on latency plus 6, 7, 7 or 8
// R4 - dll off means asynchronous termination timing
// R5 - asynchronous mode applies the pin with no additive or parity latency
// R6 - after pin high, leave park no sooner than min, reach nominal by max
// R7 - after pin low, leave nominal no sooner than min, reach park by max
// R8 - dynamic switching enabled when the write termination field is nonzero
// R9 - without writes, nominal follows pin with latency, park while pin low
// R10 - no dynamic switching with dll off; zero field disables it
// R11 - latencies fixed when each write command is registered
`default_nettype none
module dtc_top
   import dtc_pkg::*;
#(
   parameter int DEPTH = DTC_SCHED_DEPTH,
   localparam int IW = $clog2(DEPTH)
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [31:0] reg_rdata_o,
   input wire dtc_wr_cmd_t wr_cmd_i,
   input wire logic term_pin_i,
   output dtc_term_t term_sel_o,
   output logic term_changing_o
);

   // ==========================================================
   // latency decode

   // release offset above the on latency, chop-4 vs full burst
   function automatic logic [6:0] rel_add(input logic pre2, input logic crc, input logic bc4);
      logic [1:0] mode;
      mode = {pre2, crc};
      rel_add = 7'd0;
      if (bc4)
      begin
         case (mode)
            2'b00: rel_add = 7'd4; // R2
            2'b01: rel_add = 7'd7; // R2
            2'b10: rel_add = 7'd5; // R2
            default: rel_add = 7'd8; // R2
         endcase
      end
      else
      begin
         case (mode)
            2'b00: rel_add = 7'd6; // R3
            2'b11: rel_add = 7'd8; // R3
            default: rel_add = 7'd7; // R3
         endcase
      end
   endfunction

   // wl minus sub, never below one clock
   function automatic logic [6:0] lat_sub(input logic [4:0] wl, input logic [6:0] sub);
      lat_sub = ({2'b00, wl} > sub) ? {2'b00, wl} - sub : 7'd1;
   endfunction

   // a latency of n clocks lands in slot n-1 (output is one flop later)
   function automatic logic [IW-1:0] lat_idx(input logic [6:0] lat);
      lat_idx = IW'(lat - 7'd1);
   endfunction

   // ==========================================================
   // register file

   dtc_ctrl_t ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   dtc_stat_t stat_c;
   dtc_term_t term_q, term_d;
   logic chg_q, chg_d;
   logic wr_active_q, wr_active_d;
   logic sync_pin_c;

   always_comb
   begin
      stat_c.pin_dly = sync_pin_c;
      stat_c.changing = chg_q;
      stat_c.wr_active = wr_active_q;
      stat_c.sel = term_q;
   end

   // control write; read data stand only in the cycle after the strobe
   always_comb
   begin
      ctrl_d = ctrl_q;
      rdata_d = 32'h0000_0000;
      if (reg_we_i && reg_addr_i == DTC_CTRL_OFS)
      begin
         ctrl_d = dtc_ctrl_t'(reg_wdata_i[$bits(dtc_ctrl_t)-1:0]);
         ctrl_d.pad0 = 1'b0;
         ctrl_d.pad1 = 1'b0;
      end
      if (reg_re_i)
      begin
         case (reg_addr_i)
            DTC_CTRL_OFS: rdata_d = 32'(ctrl_q);
            DTC_STAT_OFS: rdata_d = 32'(stat_c);
            default: rdata_d = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= DTC_CTRL_RST;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // write termination scheduling

   logic dyn_en_c;
   logic [6:0] on_lat_c, off_lat_c, pin_lat_c;
   logic on_evt, off_evt;

   // any set bit of the write termination field enables switching
   assign dyn_en_c = (ctrl_q.write_termination != 3'b000); // R8

   // latencies taken from the settings in force at the command
   always_comb
   begin
      on_lat_c = lat_sub(ctrl_q.wl, ctrl_q.pre2 ? 7'd3 : 7'd2); // R1 R11
      off_lat_c = on_lat_c + rel_add(ctrl_q.pre2, ctrl_q.crc_en, wr_cmd_i.bc4); // R2 R3 R11
      pin_lat_c = lat_sub(ctrl_q.wl, 7'd2);
   end

   // both events are queued at the command, so later latency setting changes
   // cannot stretch or cut a write already in flight
   dtc_sched #(
      .DEPTH(DEPTH)
   ) u_on_sched (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ins_i(wr_cmd_i.valid),
      .val_i(1'b1),
      .idx_i(lat_idx(on_lat_c)), // R1 R11
      .out_o(on_evt)
   );

   dtc_sched #(
      .DEPTH(DEPTH)
   ) u_off_sched (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ins_i(wr_cmd_i.valid),
      .val_i(1'b1),
      .idx_i(lat_idx(off_lat_c)), // R2 R3 R11
      .out_o(off_evt)
   );

   // pin delayed by the synchronous on/off latency
   dtc_sched #(
      .DEPTH(DEPTH)
   ) u_pin_sched (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ins_i(1'b1),
      .val_i(term_pin_i),
      .idx_i(lat_idx(pin_lat_c)), // R9
      .out_o(sync_pin_c)
   );

   // count of open write windows, so the release of an older write
   // cannot cut a later overlapping write short; a start and a release
   // in one cycle cancel, leaving the window open
   logic [IW-1:0] open_q, open_d;

   always_comb
   begin
      open_d = open_q;
      if (on_evt && !off_evt)
         open_d = open_q + IW'(1);
      else if (off_evt && !on_evt && open_q != '0)
         open_d = open_q - IW'(1); // R2 R3
      wr_active_d = (open_d != '0);
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         open_q <= '0;
         wr_active_q <= 1'b0;
      end
      else
      begin
         open_q <= open_d;
         wr_active_q <= wr_active_d;
      end
   end

   // ==========================================================
   // termination selection

   logic async_nom, async_moving;

   // pin goes straight in, bypassing all latency
   dtc_async_timer u_async (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pin_i(term_pin_i), // R5
      .nom_o(async_nom),
      .moving_o(async_moving)
   );

   always_comb
   begin
      term_d = TERM_PARK;
      chg_d = 1'b0;
      if (ctrl_q.dll_off)
      begin
         term_d = async_nom ? TERM_NOM : TERM_PARK; // R4 R10
         chg_d = async_moving; // R6 R7
      end
      else if (wr_active_d && dyn_en_c)
         term_d = TERM_WR; // R1 R8
      else
         term_d = sync_pin_c ? TERM_NOM : TERM_PARK; // R9
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         term_q <= TERM_PARK;
         chg_q <= 1'b0;
      end
      else
      begin
         term_q <= term_d;
         chg_q <= chg_d;
      end
   end

   assign term_sel_o = term_q;
   assign term_changing_o = chg_q;
   assign reg_rdata_o = rdata_q;

   // ==========================================================
   // checks

   // countdowns from the latest write to its expected events
   logic [6:0] chk_on_q, chk_on_d, chk_off_q, chk_off_d;

   always_comb
   begin
      chk_on_d = (chk_on_q != 7'd0) ? chk_on_q - 7'd1 : 7'd0;
      chk_off_d = (chk_off_q != 7'd0) ? chk_off_q - 7'd1 : 7'd0;
      if (wr_cmd_i.valid)
      begin
         chk_on_d = on_lat_c;
         chk_off_d = off_lat_c;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         chk_on_q <= 7'd0;
         chk_off_q <= 7'd0;
      end
      else
      begin
         chk_on_q <= chk_on_d;
         chk_off_q <= chk_off_d;
      end
   end

   a_wr_on_time: assert property ( // R1
      @(posedge ref_clk_i) disable iff (rst_i)
      (chk_on_q == 7'd1 && dyn_en_c && !ctrl_q.dll_off) |=> (term_sel_o == TERM_WR))
      else $error("write termination not selected at on latency");

   a_wr_release: assert property ( // R2 R3
      @(posedge ref_clk_i) disable iff (rst_i)
      (chk_off_q == 7'd1) |=> (term_sel_o != TERM_WR))
      else $error("write termination not released at release latency");

   a_no_dyn_dll: assert property ( // R10
      @(posedge ref_clk_i) disable iff (rst_i)
      ctrl_q.dll_off |=> (term_sel_o != TERM_WR))
      else $error("write termination selected with dll off");

   a_dyn_gate: assert property ( // R8
      @(posedge ref_clk_i) disable iff (rst_i)
      !dyn_en_c |=> (term_sel_o != TERM_WR))
      else $error("write termination selected while disabled");

   a_park_pin_low: assert property ( // R9
      @(posedge ref_clk_i) disable iff (rst_i)
      (!ctrl_q.dll_off && !sync_pin_c && !wr_active_d) |=> (term_sel_o == TERM_PARK))
      else $error("park termination missing while pin low");

   a_async_mode: assert property ( // R4 R5
      @(posedge ref_clk_i) disable iff (rst_i)
      (ctrl_q.dll_off && async_nom) |=> (term_sel_o == TERM_NOM))
      else $error("dll off termination does not follow async timer");

endmodule
`default_nettype wire

// ---- pkg/dtc_pkg.sv ----
`default_nettype none
package dtc_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] DTC_CTRL_OFS = 8'h00;
   localparam logic [7:0] DTC_STAT_OFS = 8'h04;

   // control word, low bits of the data bus
   typedef struct packed {
      logic [4:0] wl;       // write latency in clocks
      logic pad1;
      logic [2:0] write_termination;   // mode_register_two write termination value
      logic pad0;
      logic crc_en;         // write crc mode
      logic pre2;           // two-clock write preamble
      logic dll_off;        // dll turned off
   } dtc_ctrl_t;

   localparam dtc_ctrl_t DTC_CTRL_RST = 13'h0b00;

   // termination strength selection
   typedef enum logic [1:0] {
      TERM_PARK = 2'b00,
      TERM_NOM = 2'b01,
      TERM_WR = 2'b10
   } dtc_term_t;

   // status word
   typedef struct packed {
      logic pin_dly;        // pin level after sync latency
      logic changing;       // asynchronous transition under way
      logic wr_active;      // write termination window open
      dtc_term_t sel;
   } dtc_stat_t;

   // write command as registered by the command decoder
   typedef struct packed {
      logic valid;
      logic bc4;            // burst chop 4, fixed or on the fly
   } dtc_wr_cmd_t;

   typedef enum logic [1:0] {
      AS_IDLE = 2'b00,
      AS_WAIT = 2'b01,
      AS_MOVE = 2'b10
   } dtc_async_t;

   // ==========================================================
   // timing
   localparam int DTC_CLK_NS = 8;
   localparam int ASYNC_ON_MIN_NS = 8;
   localparam int ASYNC_ON_MAX_NS = 24;
   localparam int ASYNC_OFF_MIN_NS = 8;
   localparam int ASYNC_OFF_MAX_NS = 24;
   localparam int ASYNC_ON_MIN_CYC = (ASYNC_ON_MIN_NS + DTC_CLK_NS - 1) / DTC_CLK_NS;
   localparam int ASYNC_ON_MAX_CYC = (ASYNC_ON_MAX_NS / DTC_CLK_NS < 1) ? 1 : ASYNC_ON_MAX_NS / DTC_CLK_NS;
   localparam int ASYNC_OFF_MIN_CYC = (ASYNC_OFF_MIN_NS + DTC_CLK_NS - 1) / DTC_CLK_NS;
   localparam int ASYNC_OFF_MAX_CYC = (ASYNC_OFF_MAX_NS / DTC_CLK_NS < 1) ? 1 : ASYNC_OFF_MAX_NS / DTC_CLK_NS;
   localparam int DTC_SCHED_DEPTH = 64;

endpackage
`default_nettype wire

// ---- testbench/dtc_ctl_model.sv ----
`default_nettype none
// ==========================================================
// controller side: write commands and termination pin level
module dtc_ctl_model
   import dtc_pkg::*;
(
   input wire logic ref_clk_i,
   output dtc_wr_cmd_t wr_cmd_o,
   output logic term_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic v_q = 1'b0;
   logic b_q = 1'b0;
   logic idle_q = 1'b0;
   initial term_pin_o = 1'b0;
   // chop bit is junk outside a command, so a held value cannot hide a bug
   always @(posedge ref_clk_i)
   begin
      idle_q <= ~idle_q;
   end
   assign wr_cmd_o = '{valid: v_q, bc4: v_q ? b_q : idle_q};
   // callers sit just after a rising edge; set_pin returns one edge later, send_write n plus one edges later
   task automatic send_write(input logic bc4, input int n);
      for (int i = 0; i < n; i++)
      begin
         v_q <= 1'b1;
         b_q <= bc4;
         @(posedge ref_clk_i);
      end
      v_q <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic set_pin(input logic lvl);
      term_pin_o <= lvl;
      @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb
   import dtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // expectation codes: [3] check changing, [2] changing, [1:0] selection
   localparam logic [3:0] PK = 4'h0;
   localparam logic [3:0] NM = 4'h1;
   localparam logic [3:0] WT = 4'h2;
   localparam logic [3:0] AP = 4'h8;
   localparam logic [3:0] AN = 4'h9;
   localparam logic [3:0] ACP = 4'hc;
   localparam logic [3:0] ACN = 4'hd;
   localparam int ADD4[4] = '{4, 7, 5, 8};
   localparam int ADD8[4] = '{6, 7, 7, 8};
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h00000000;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [31:0] reg_rdata_o;
   dtc_wr_cmd_t wr_cmd;
   logic term_pin;
   dtc_term_t term_sel_o;
   logic term_changing_o;
   int errors = 0;
   int samples_checked = 0;
   int seed = 5201;
   logic [3:0] tq[$];
   logic [31:0] rq[$];
   logic rd_pend = 1'b0;

   // 125 MHz
   always #4 ref_clk_i = ~ref_clk_i;

   dtc_ctl_model i_ctl (.ref_clk_i(ref_clk_i), .wr_cmd_o(wr_cmd), .term_pin_o(term_pin));
   dtc_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .wr_cmd_i(wr_cmd),
      .term_pin_i(term_pin), .term_sel_o(term_sel_o), .term_changing_o(term_changing_o));

   // ==========================================================
   // checking
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // outputs have settled by the falling edge, so compare there
   always @(negedge ref_clk_i)
   begin
      logic [3:0] e;
      if (rd_pend)
         cmp(reg_rdata_o, rq.pop_front(), "read data");
      rd_pend = reg_re_i;
      if (tq.size() != 0)
      begin
         e = tq.pop_front();
         cmp(32'(term_sel_o), 32'(e[1:0]), "selection");
         if (e[3])
            cmp(32'(term_changing_o), 32'(e[2]), "changing");
      end
   end
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // register bus, one strobe then an idle edge
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_we_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_re_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // random pad bits must read back as zero; a stray write elsewhere must not land
   task automatic cfg(input int wl, input int fld, input logic crc, input logic pre2, input logic dll);
      logic [31:0] w;
      w = {19'($random(seed)), 5'(wl), 1'($random(seed)), 3'(fld), 1'($random(seed)), crc, pre2, dll};
      reg_wr(8'h00, w);
      reg_wr(8'h08, ~w);
      reg_rd(8'h00, w & 32'h00001f77);
   endtask
   // a before lo, b from lo to hi, c after; one entry per cycle
   task automatic expect3(input int n, input int lo, input int hi, input logic [3:0] a, b, c);
      for (int j = 0; j < n; j++)
         tq.push_back(j < lo ? a : (j <= hi ? b : c));
   endtask
   task automatic drain(input string name);
      while (tq.size() != 0 || rq.size() != 0)
         @(posedge ref_clk_i);
      $display("test %s done", name);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      int wl;
      int fld;
      int add;
      int n;
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      reg_rd(8'h00, 32'h00000b00);
      reg_rd(8'h04, 32'h00000000);
      reg_rd(8'h0c, 32'h00000000);
      drain("reset");
      // every preamble, crc and burst pairing, some with back-to-back commands
      for (int c = 0; c < 8; c++)
      begin
         wl = 8 + ($unsigned($random(seed)) % 8);
         fld = 1 + ($unsigned($random(seed)) % 7);
         cfg(wl, fld, c[2], c[1], 1'b0);
         add = c[0] ? ADD4[2 * c[1] + c[2]] : ADD8[2 * c[1] + c[2]];
         n = (c % 3 == 0) ? 2 : 1;
         wl = wl - 2 - c[1];
         expect3(wl + add + n + 3, wl + 1, wl + add + n - 1, PK, WT, PK);
         i_ctl.send_write(c[0], n);
         drain("write window");
      end
      // settings changed mid-window must not move it
      cfg(11, 1, 1'b0, 1'b0, 1'b0);
      expect3(19, 10, 15, PK, WT, PK);
      i_ctl.send_write(1'b0, 1);
      cfg(11, 5, 1'b1, 1'b1, 1'b0);
      repeat (2) @(posedge ref_clk_i);
      reg_rd(8'h04, 32'h00000006);
      drain("latched latency");
      cfg(11, 1, 1'b0, 1'b0, 1'b0);
      expect3(14, 10, 13, PK, NM, NM);
      i_ctl.set_pin(1'b1);
      drain("pin high");
      reg_rd(8'h04, 32'h00000011);
      expect3(19, 10, 15, NM, WT, NM);
      i_ctl.send_write(1'b0, 1);
      drain("write over nominal");
      cfg(11, 0, 1'b0, 1'b0, 1'b0);
      expect3(20, 0, 0, NM, NM, NM);
      i_ctl.send_write(1'b1, 1);
      drain("field zero");
      expect3(14, 10, 13, NM, PK, PK);
      i_ctl.set_pin(1'b0);
      drain("pin low");
      // dll off: long write latency must not delay the pin
      cfg(20, 3, 1'b0, 1'b0, 1'b1);
      expect3(6, 2, 3, AP, ACP, AN);
      i_ctl.set_pin(1'b1);
      drain("async on");
      expect3(20, 0, 0, AN, AN, AN);
      i_ctl.send_write(1'b0, 1);
      drain("async write");
      expect3(6, 2, 3, AN, ACN, AP);
      i_ctl.set_pin(1'b0);
      drain("async off");
      stop_test();
   end

   // the whole run needs under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
